/* File: hw/gpm_params.svh */
`ifndef GPM_PARAMS_SVH
`define GPM_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define GPM_ADDR_DIR 16'h006E
`define GPM_ADDR_ISEL_B2 16'h006F
`define GPM_ADDR_ISEL_B1 16'h0070
`define GPM_ADDR_ISEL_B0 16'h0071
`define GPM_ADDR_OSEL_B2 16'h0072
`define GPM_ADDR_OSEL_B1 16'h0073
`define GPM_ADDR_OSEL_B0 16'h0074
`define GPM_ADDR_GAP 16'h0075
`define GPM_ADDR_OUT_VAL 16'h0076
`define GPM_ADDR_IN_VAL 16'h0077

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define GPM_RST_DIR 8'h00
`define GPM_RST_ISEL 8'h00
`define GPM_RST_OUT_VAL 8'h00
`define GPM_RST_RDATA 8'h00
`define GPM_RST_PINS 8'h00
`define GPM_RST_CLK_EN 5'h1F
`define GPM_RST_CTRL 5'h00

// ----------------------------------------------------------------
// Field values
// ----------------------------------------------------------------
`define GPM_DIR_INPUT 1'b0
`define GPM_ISEL_PLAIN 3'h0
`define GPM_ISEL_OUT_EN 3'h1
`define GPM_ISEL_REF_SEL 3'h5
`define GPM_PIN_COUNT 8
`define GPM_OE_PIN_COUNT 5

`endif

/* File: hw/gpm_pkg.sv */
package gpm_pkg;
    typedef logic [7:0] gpm_byte_t;
    typedef logic [15:0] gpm_addr_t;
    typedef logic [2:0] gpm_sel_t;
    typedef logic [4:0] gpm_clk_vec_t;
endpackage

/* File: hw/gpm_pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gpm_params.svh"

module gpm_pin_sync (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire gpm_pkg::gpm_byte_t pins_in,
    output gpm_pkg::gpm_byte_t level_out
);
    import gpm_pkg::*;

    // ----------------------------------------------------------------
    // Three-stage capture
    // ----------------------------------------------------------------
    // First stage feeds only the second; metastability stays contained
    gpm_byte_t stage1_q;
    gpm_byte_t stage2_q;
    gpm_byte_t stage3_q;
    gpm_byte_t level_q;
    gpm_byte_t level_d;
    gpm_byte_t agree;

    assign agree = ~(stage2_q ^ stage3_q);
    assign level_d = (agree & stage3_q) | (~agree & level_q);
    assign level_out = level_q;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stage1_q <= `GPM_RST_PINS;
            stage2_q <= `GPM_RST_PINS;
            stage3_q <= `GPM_RST_PINS;
            level_q <= `GPM_RST_PINS;
        end else begin
            stage1_q <= pins_in;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
            level_q <= level_d;
        end
    end
endmodule

`default_nettype wire

/* File: hw/gpm_pin_function_mux.sv */
// Functional notes
// RL1: An eight-bit read-write direction field holds one bit per pin and resets to zero.
// RL2: A pin's input function select acts only while its direction bit makes it an input.
// RL3: Each input select is a 3-bit read-write field reset to zero; code zero shows the pin level in the input-value bit.
// RL4: Pin 0 as input with code one drives the output-enable of clock output 0.
// RL5: Codes two to seven of pin 0's select are reserved and do nothing.
// RL6: Pin 2 as input with code one drives the output-enable of clock output 2.
// RL7: Pin 2 with code five drives bit 0 of the first PLL's manual reference select.
// RL8: Pin 3 as input with code one drives the output-enable of clock output 3.
// RL9: Pin 3 with code five drives bit 0 of the second PLL's manual reference select; codes 2, 3, 4, 6, 7 are reserved.
// RL10: A pin in output mode is driven from its bit of the output-value register.
// RL11: Pins 1 and 4 behave like pin 0: code zero plain input, code one output-enable, others reserved.
// RL12: Direction zero means input, so after reset every pin is a plain input.
`timescale 1ns/10ps
`default_nettype none
`include "gpm_params.svh"

module gpm_pin_function_mux (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire gpm_pkg::gpm_addr_t reg_addr_in,
    input wire logic reg_wr_en_in,
    input wire gpm_pkg::gpm_byte_t reg_wr_data_in,
    input wire logic reg_rd_en_in,
    output gpm_pkg::gpm_byte_t reg_rd_data_out,
    output logic reg_rd_valid_out,
    input wire gpm_pkg::gpm_byte_t gpio_pins_in,
    output gpm_pkg::gpm_byte_t gpio_pins_out,
    output gpm_pkg::gpm_byte_t gpio_pins_oe_out,
    output gpm_pkg::gpm_clk_vec_t clock_output_enable_out,
    output gpm_pkg::gpm_clk_vec_t clock_output_pin_ctrl_out,
    output logic first_pll_manual_ref_select_out,
    output logic first_pll_manual_ref_ctrl_out,
    output logic second_pll_manual_ref_select_out,
    output logic second_pll_manual_ref_ctrl_out
);
    import gpm_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Select code of one pin from the three bit-plane registers
    function automatic gpm_sel_t sel_of(input gpm_byte_t b2, input gpm_byte_t b1,
                                        input gpm_byte_t b0, input int unsigned idx);
        gpm_sel_t code;
        code = {b2[idx[2:0]], b1[idx[2:0]], b0[idx[2:0]]};
        return code;
    endfunction

    // True when the pin is an input and its select holds the given code
    function automatic logic func_active(input logic dir_bit, input gpm_sel_t code,
                                         input gpm_sel_t want);
        logic hit;
        hit = (dir_bit == `GPM_DIR_INPUT) && (code == want);
        return hit;
    endfunction

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    gpm_byte_t dir_q;
    gpm_byte_t dir_d;
    gpm_byte_t isel_b2_q;
    gpm_byte_t isel_b2_d;
    gpm_byte_t isel_b1_q;
    gpm_byte_t isel_b1_d;
    gpm_byte_t isel_b0_q;
    gpm_byte_t isel_b0_d;
    gpm_byte_t out_val_q;
    gpm_byte_t out_val_d;
    gpm_byte_t rd_data_q;
    gpm_byte_t rd_data_d;
    logic rd_valid_q;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire logic hit_dir;
    wire logic hit_b2;
    wire logic hit_b1;
    wire logic hit_b0;
    wire logic hit_out;
    wire logic hit_in;

    assign hit_dir = (reg_addr_in == `GPM_ADDR_DIR);
    assign hit_b2 = (reg_addr_in == `GPM_ADDR_ISEL_B2);
    assign hit_b1 = (reg_addr_in == `GPM_ADDR_ISEL_B1);
    assign hit_b0 = (reg_addr_in == `GPM_ADDR_ISEL_B0);
    assign hit_out = (reg_addr_in == `GPM_ADDR_OUT_VAL);
    assign hit_in = (reg_addr_in == `GPM_ADDR_IN_VAL);

    // ----------------------------------------------------------------
    // Write path
    // ----------------------------------------------------------------
    assign dir_d = (reg_wr_en_in && hit_dir) ? reg_wr_data_in : dir_q; // [RL1]
    // All three planes store every pin so software reads back what it wrote
    assign isel_b2_d = (reg_wr_en_in && hit_b2) ? reg_wr_data_in : isel_b2_q; // [RL3]
    assign isel_b1_d = (reg_wr_en_in && hit_b1) ? reg_wr_data_in : isel_b1_q; // [RL3]
    assign isel_b0_d = (reg_wr_en_in && hit_b0) ? reg_wr_data_in : isel_b0_q; // [RL3]
    assign out_val_d = (reg_wr_en_in && hit_out) ? reg_wr_data_in : out_val_q;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dir_q <= `GPM_RST_DIR; // [RL1] [RL12]
        end else begin
            dir_q <= dir_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            isel_b2_q <= `GPM_RST_ISEL; // [RL3]
        end else begin
            isel_b2_q <= isel_b2_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            isel_b1_q <= `GPM_RST_ISEL; // [RL3]
        end else begin
            isel_b1_q <= isel_b1_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            isel_b0_q <= `GPM_RST_ISEL; // [RL3]
        end else begin
            isel_b0_q <= isel_b0_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            out_val_q <= `GPM_RST_OUT_VAL;
        end else begin
            out_val_q <= out_val_d;
        end
    end

    // ----------------------------------------------------------------
    // Pin capture
    // ----------------------------------------------------------------
    gpm_byte_t pin_level;

    gpm_pin_sync u_pin_sync (
        .ref_clk_in(ref_clk_in),
        .reset_n_in(reset_n_in),
        .pins_in(gpio_pins_in),
        .level_out(pin_level)
    );

    // ----------------------------------------------------------------
    // Per-pin select codes
    // ----------------------------------------------------------------
    gpm_sel_t sel0;
    gpm_sel_t sel1;
    gpm_sel_t sel2;
    gpm_sel_t sel3;
    gpm_sel_t sel4;

    assign sel0 = sel_of(isel_b2_q, isel_b1_q, isel_b0_q, 0);
    assign sel1 = sel_of(isel_b2_q, isel_b1_q, isel_b0_q, 1);
    assign sel2 = sel_of(isel_b2_q, isel_b1_q, isel_b0_q, 2);
    assign sel3 = sel_of(isel_b2_q, isel_b1_q, isel_b0_q, 3);
    assign sel4 = sel_of(isel_b2_q, isel_b1_q, isel_b0_q, 4);

    // ----------------------------------------------------------------
    // Input function decode
    // ----------------------------------------------------------------
    // Reserved codes fall through every compare below and steer nothing
    gpm_clk_vec_t oe_ctrl;
    gpm_clk_vec_t oe_ctrl_d;
    gpm_clk_vec_t clk_en_d;
    wire logic ref0_ctrl;
    wire logic ref1_ctrl;

    assign oe_ctrl[0] = func_active(dir_q[0], sel0, `GPM_ISEL_OUT_EN); // [RL2] [RL4] [RL5]
    assign oe_ctrl[1] = func_active(dir_q[1], sel1, `GPM_ISEL_OUT_EN); // [RL2] [RL11]
    assign oe_ctrl[2] = func_active(dir_q[2], sel2, `GPM_ISEL_OUT_EN); // [RL2] [RL6]
    assign oe_ctrl[3] = func_active(dir_q[3], sel3, `GPM_ISEL_OUT_EN); // [RL2] [RL8] [RL9]
    assign oe_ctrl[4] = func_active(dir_q[4], sel4, `GPM_ISEL_OUT_EN); // [RL2] [RL11]
    assign ref0_ctrl = func_active(dir_q[2], sel2, `GPM_ISEL_REF_SEL); // [RL2] [RL7]
    assign ref1_ctrl = func_active(dir_q[3], sel3, `GPM_ISEL_REF_SEL); // [RL2] [RL9]

    assign oe_ctrl_d = oe_ctrl;
    // Clock outputs not under pin control stay enabled
    assign clk_en_d = (oe_ctrl & pin_level[4:0]) | ~oe_ctrl; // [RL4] [RL6] [RL8] [RL11]

    // ----------------------------------------------------------------
    // Function outputs
    // ----------------------------------------------------------------
    gpm_clk_vec_t clk_en_q;
    gpm_clk_vec_t oe_ctrl_q;
    logic ref0_sel_q;
    logic ref0_sel_d;
    logic ref0_ctrl_q;
    logic ref1_sel_q;
    logic ref1_sel_d;
    logic ref1_ctrl_q;

    // Last value held when the pin hands back control, avoids a glitch
    assign ref0_sel_d = ref0_ctrl ? pin_level[2] : ref0_sel_q; // [RL7]
    assign ref1_sel_d = ref1_ctrl ? pin_level[3] : ref1_sel_q; // [RL9]

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            clk_en_q <= `GPM_RST_CLK_EN;
            oe_ctrl_q <= `GPM_RST_CTRL;
        end else begin
            clk_en_q <= clk_en_d;
            oe_ctrl_q <= oe_ctrl_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ref0_sel_q <= 1'b0;
            ref0_ctrl_q <= 1'b0;
        end else begin
            ref0_sel_q <= ref0_sel_d;
            ref0_ctrl_q <= ref0_ctrl;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ref1_sel_q <= 1'b0;
            ref1_ctrl_q <= 1'b0;
        end else begin
            ref1_sel_q <= ref1_sel_d;
            ref1_ctrl_q <= ref1_ctrl;
        end
    end

    assign clock_output_enable_out = clk_en_q;
    assign clock_output_pin_ctrl_out = oe_ctrl_q;
    assign first_pll_manual_ref_select_out = ref0_sel_q;
    assign first_pll_manual_ref_ctrl_out = ref0_ctrl_q;
    assign second_pll_manual_ref_select_out = ref1_sel_q;
    assign second_pll_manual_ref_ctrl_out = ref1_ctrl_q;

    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    gpm_byte_t pins_q;
    gpm_byte_t pins_oe_q;
    gpm_byte_t pins_oe_d;

    // Only the plain output function exists, so output mode drives the value bit
    assign pins_oe_d = dir_q; // [RL10] [RL12]

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pins_q <= `GPM_RST_PINS;
        end else begin
            pins_q <= out_val_q; // [RL10]
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pins_oe_q <= `GPM_RST_PINS;
        end else begin
            pins_oe_q <= pins_oe_d;
        end
    end

    assign gpio_pins_out = pins_q;
    assign gpio_pins_oe_out = pins_oe_q;

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Input values show every pin's filtered level whatever its function
    gpm_byte_t rd_mux;

    assign rd_mux = hit_dir ? dir_q :
                    hit_b2 ? isel_b2_q :
                    hit_b1 ? isel_b1_q :
                    hit_b0 ? isel_b0_q :
                    hit_out ? out_val_q :
                    hit_in ? pin_level : // [RL3]
                    `GPM_RST_RDATA;
    assign rd_data_d = reg_rd_en_in ? rd_mux : rd_data_q;

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_q <= `GPM_RST_RDATA;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= reg_rd_en_in;
        end
    end

    assign reg_rd_data_out = rd_data_q;
    assign reg_rd_valid_out = rd_valid_q;
endmodule

`default_nettype wire

/* File: sim/gpm_pin_function_mux_chk.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gpm_params.svh"
module gpm_pin_function_mux_chk (
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire gpm_pkg::gpm_addr_t reg_addr_in,
    input wire logic reg_wr_en_in,
    input wire gpm_pkg::gpm_byte_t reg_wr_data_in,
    input wire logic reg_rd_en_in,
    input wire logic reg_rd_valid_out,
    input wire gpm_pkg::gpm_byte_t gpio_pins_in,
    input wire gpm_pkg::gpm_byte_t gpio_pins_out,
    input wire gpm_pkg::gpm_byte_t gpio_pins_oe_out,
    input wire gpm_pkg::gpm_clk_vec_t clock_output_enable_out,
    input wire gpm_pkg::gpm_clk_vec_t clock_output_pin_ctrl_out,
    input wire logic first_pll_manual_ref_select_out,
    input wire logic first_pll_manual_ref_ctrl_out
);
    import gpm_pkg::*;
    // ------------------------------------------------
    // Port relations
    // ------------------------------------------------
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    sequence s_dir_wr;
        reg_wr_en_in && reg_addr_in == `GPM_ADDR_DIR;
    endsequence
    sequence s_val_wr;
        reg_wr_en_in && reg_addr_in == `GPM_ADDR_OUT_VAL;
    endsequence
    // Seven quiet edges cover the three-flop filter plus output stage
    sequence s_ref_pin;
        first_pll_manual_ref_ctrl_out && $stable(gpio_pins_in[2]);
    endsequence
    sequence s_oe_pin;
        clock_output_pin_ctrl_out[0] && $stable(gpio_pins_in[0]);
    endsequence
    dir_to_oe_a:
        assert property (s_dir_wr |=> ##1 gpio_pins_oe_out == $past(reg_wr_data_in, 2))
        else $error("oe does not follow direction write");
    out_val_a:
        assert property (s_val_wr |=> ##1 gpio_pins_out == $past(reg_wr_data_in, 2))
        else $error("pin drive does not follow output value");
    read_valid_a:
        assert property (reg_rd_en_in |=> reg_rd_valid_out)
        else $error("read not answered");
    read_idle_a:
        assert property (!reg_rd_en_in |=> !reg_rd_valid_out)
        else $error("read valid without read");
    input_only_a:
        assert property ((clock_output_pin_ctrl_out & gpio_pins_oe_out[4:0]) == 5'h00)
        else $error("output pin steers a clock enable");
    idle_enable_a:
        assert property ((clock_output_enable_out | clock_output_pin_ctrl_out) == 5'h1F)
        else $error("unsteered clock output disabled");
    ref_hold_a:
        assert property ((!first_pll_manual_ref_ctrl_out [*2]) |-> $stable(first_pll_manual_ref_select_out))
        else $error("reference select moved while not steered");
    ref_follow_a:
        assert property (s_ref_pin [*7] |-> first_pll_manual_ref_select_out == gpio_pins_in[2])
        else $error("reference select does not follow pin");
    oe_follow_a:
        assert property (s_oe_pin [*7] |-> clock_output_enable_out[0] == gpio_pins_in[0])
        else $error("clock enable does not follow pin");
endmodule
bind gpm_pin_function_mux gpm_pin_function_mux_chk u_gpm_pin_function_mux_chk (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wr_en_in(reg_wr_en_in), .reg_wr_data_in(reg_wr_data_in),
    .reg_rd_en_in(reg_rd_en_in), .reg_rd_valid_out(reg_rd_valid_out),
    .gpio_pins_in(gpio_pins_in), .gpio_pins_out(gpio_pins_out),
    .gpio_pins_oe_out(gpio_pins_oe_out), .clock_output_enable_out(clock_output_enable_out),
    .clock_output_pin_ctrl_out(clock_output_pin_ctrl_out),
    .first_pll_manual_ref_select_out(first_pll_manual_ref_select_out),
    .first_pll_manual_ref_ctrl_out(first_pll_manual_ref_ctrl_out)
);
`default_nettype wire

/* File: sim/gpm_board_model.sv */
`timescale 1ns/10ps
`default_nettype none
module gpm_board_model (
    input wire gpm_pkg::gpm_byte_t drive_in,
    input wire gpm_pkg::gpm_byte_t dev_pins_in,
    input wire gpm_pkg::gpm_byte_t dev_oe_in,
    output var gpm_pkg::gpm_byte_t level_out
);
    import gpm_pkg::*;
    // ------------------------------------------------
    // Wire level
    // ------------------------------------------------
    // Board drive is weak, so the device wins wherever it is enabled
    assign level_out = (dev_oe_in & dev_pins_in) | (~dev_oe_in & drive_in);
endmodule
`default_nettype wire

/* File: sim/tb_gpm_pin_function_mux.sv */
`timescale 1ns/10ps
`default_nettype none
`include "gpm_params.svh"
module tb_gpm_pin_function_mux;
    import gpm_pkg::*;
    logic clk, rst_n, wr_en, rd_en, rv, r1s, r1c, r2s, r2c;
    gpm_addr_t addr;
    gpm_byte_t wdata, rdata, lvl, pout, poe, drv;
    gpm_clk_vec_t ck_en, ck_ctl;
    int errors, tests_run;
    gpm_pin_function_mux u_gpm_pin_function_mux (
        .ref_clk_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr), .reg_wr_en_in(wr_en),
        .reg_wr_data_in(wdata), .reg_rd_en_in(rd_en), .reg_rd_data_out(rdata),
        .reg_rd_valid_out(rv), .gpio_pins_in(lvl), .gpio_pins_out(pout),
        .gpio_pins_oe_out(poe), .clock_output_enable_out(ck_en),
        .clock_output_pin_ctrl_out(ck_ctl), .first_pll_manual_ref_select_out(r1s),
        .first_pll_manual_ref_ctrl_out(r1c), .second_pll_manual_ref_select_out(r2s),
        .second_pll_manual_ref_ctrl_out(r2c)
    );
    gpm_board_model u_gpm_board_model (
        .drive_in(drv), .dev_pins_in(pout), .dev_oe_in(poe), .level_out(lvl)
    );
    // ------------------------------------------------
    // Tasks
    // ------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input gpm_byte_t got, input gpm_byte_t exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input gpm_addr_t a, input gpm_byte_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input gpm_addr_t a, input gpm_byte_t exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk({7'h00, rv}, 8'h01);
        chk(rdata, exp);
    endtask
    // Settle covers filter plus output stage
    task automatic settle();
        repeat (8) @(posedge clk);
        #1;
    endtask
    // Low plane first, so stepping up never passes through code five
    task automatic set_code(input gpm_sel_t c);
        wr(`GPM_ADDR_ISEL_B0, {8{c[0]}});
        wr(`GPM_ADDR_ISEL_B1, {8{c[1]}});
        wr(`GPM_ADDR_ISEL_B2, {8{c[2]}});
        settle();
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk);
        errors++;
        give_verdict();
    end
    // ------------------------------------------------
    // Sequence
    // ------------------------------------------------
    initial begin
        rst_n = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 16'h0000;
        wdata = 8'h00;
        drv = 8'h00;
        errors = 0;
        tests_run = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        chk(poe, 8'h00);
        chk({3'h0, ck_en}, 8'h1F);
        for (int a = 'h6E; a <= 'h71; a++) begin
            rd(gpm_addr_t'(a), 8'h00);
        end
        wr(`GPM_ADDR_DIR, 8'hA5);
        rd(`GPM_ADDR_DIR, 8'hA5);
        wr(`GPM_ADDR_ISEL_B1, 8'h5A);
        rd(`GPM_ADDR_ISEL_B1, 8'h5A);
        wr(`GPM_ADDR_ISEL_B1, 8'h00);
        wr(`GPM_ADDR_DIR, 8'h00);
        drv <= 8'h5A;
        settle();
        rd(`GPM_ADDR_IN_VAL, 8'h5A);
        wr(`GPM_ADDR_OUT_VAL, 8'h3C);
        wr(`GPM_ADDR_DIR, 8'hFF);
        settle();
        chk(pout, 8'h3C);
        rd(`GPM_ADDR_IN_VAL, 8'h3C);
        wr(`GPM_ADDR_DIR, 8'h00);
        drv <= 8'h0C;
        for (int c = 0; c < 8; c++) begin
            set_code(gpm_sel_t'(c));
            chk({3'h0, ck_ctl}, (c == 1) ? 8'h1F : 8'h00);
            chk({3'h0, ck_en}, (c == 1) ? 8'h0C : 8'h1F);
            chk({6'h00, r2c, r1c}, (c == 5) ? 8'h03 : 8'h00);
            chk({6'h00, r2s, r1s}, (c >= 5) ? 8'h03 : 8'h00);
            rd(`GPM_ADDR_IN_VAL, 8'h0C);
        end
        set_code(3'h5);
        drv <= 8'h00;
        settle();
        chk({6'h00, r2s, r1s}, 8'h00);
        wr(`GPM_ADDR_DIR, 8'h0C);
        drv <= 8'h0C;
        settle();
        chk({4'h0, r2c, r2s, r1c, r1s}, 8'h00);
        set_code(3'h1);
        chk({3'h0, ck_ctl}, 8'h13);
        chk({3'h0, ck_en}, 8'h0C);
        give_verdict();
    end
endmodule
`default_nettype wire
